//--- pkg/fault_mon_pkg.sv
// Constants, carriers and state layout of the processor fault monitor
package fault_mon_pkg;
  // ****************************************************
  // Sizes and register map (byte addresses)
  // ****************************************************
  localparam int          NCPU    = 4;
  localparam int          TW      = 33;
  localparam logic [7:0]  A_CTRL  = 8'h00;
  localparam logic [7:0]  A_REARM = 8'h04;
  localparam logic [7:0]  A_STAT  = 8'h08;
  localparam logic [7:0]  A_ISTAT = 8'h0C;
  localparam logic [7:0]  A_ICLR  = 8'h10;
  localparam logic [7:0]  A_IEN   = 8'h14;
  localparam logic [7:0]  A_LAST  = 8'h18;
  localparam logic [1:0]  CTRL_RST = 2'h0;
  localparam logic [1:0]  INIT_RST = 2'h3;
  // ****************************************************
  // Event record codes
  // ****************************************************
  localparam logic [7:0]  RD_TYPE      = 8'h03;
  localparam logic [7:0]  SN_TYPE      = 8'h07;
  localparam logic [7:0]  OFS_ASSERT   = 8'h01;
  localparam logic [7:0]  OFS_PRESENT  = 8'h07;
  localparam logic [7:0]  ED2_UNKNOWN  = 8'h00;
  localparam logic [7:0]  ED2_CATASTROPHIC_ERROR_LINE   = 8'h01;
  localparam logic [7:0]  ED2_MISMATCH = 8'h03;
  // Pending-event slots and interrupt bits
  localparam int          P_PRES = 0;
  localparam int          P_POP  = 4;
  localparam int          P_IO   = 5;
  localparam int          P_CAT  = 9;
  localparam int          P_SEGMENT_POWER_ID = 10;
  localparam int          NPEND  = 11;
  localparam int          NIRQ   = 5;
  // ****************************************************
  // Times and derived cycle counts
  // ****************************************************
  localparam longint CLK_HZ    = 50_000_000;
  localparam longint ERRTO_S   = 90;
  localparam longint BEEP_MS   = 500;
  localparam longint HOLD_US   = 1000;
  localparam longint QRY_US    = 10;
  localparam longint ERRTO_CYC = ERRTO_S * CLK_HZ;
  localparam longint BEEP_CYC  = BEEP_MS * CLK_HZ / 1000;
  localparam longint HOLD_CYC  = HOLD_US * CLK_HZ / 1_000_000;
  localparam logic [15:0] QRY_CYC = 16'(QRY_US * CLK_HZ / 1_000_000);
  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [2:0] {K_PRES, K_POP, K_IOTO, K_CAT, K_SEGMENT_POWER_ID} kind_e;
  typedef enum logic [2:0] {C_IDLE, C_QUERY, C_WAIT, C_DECIDE,
                            C_HUNG} cat_e;
  typedef struct packed {
    kind_e      kind;
    logic [1:0] cpu;
    logic       deassert;
    logic [7:0] rd_type;
    logic [7:0] sn_type;
    logic [7:0] offset;
    logic [7:0] ed2;
    logic [7:0] ed3;
  } event_s;
  typedef struct packed {
    logic [NCPU-1:0] pres_s1, pres_s2, io_s1, io_s2;
    logic cat_s1, cat_s2, pwr_s1, pwr_s2, pwr_s3, rst_s1, rst_s2, rst_s3;
    logic [1:0] init_cnt;
    logic [NCPU-1:0] present;
    logic pop_fault;
    logic [NCPU-1:0][TW-1:0] io_cnt;
    logic [NCPU-1:0] io_to;
    logic [TW-1:0] hold_cnt;
    cat_e cst;
    logic [1:0] qcpu;
    logic [NCPU-1:0] src_map;
    logic mismatch, answered, cat_armed, cat_asserted, segment_power_id_asserted;
    logic [NPEND-1:0] pend, pdir;
    event_s evt;
    logic evt_valid;
    logic [1:0] ctrl;
    logic [NIRQ-1:0] istat, ien;
    logic irq, reset_req, fault_led, beep, qry_req;
    logic [TW-1:0] beep_cnt;
    logic [15:0] qry_cnt;
    logic [31:0] prdata;
    logic pready, pslverr;
  } state_s;
endpackage

//--- core/processor_fault_monitor.sv
// Processor presence, error-timeout and catastrophic-error monitor
//
// Contract
// [R1] Startup clears presence, then samples every socket
// [R2] Presence re-sampled at power-on and system reset
// [R3] Presence events only on change or rearm
// [R4] Population fault checked; beep on failing power-on
// [R5] Fatal I/O line held over limit times out
// [R6] Timeout logs event; reset unless disabled
// [R7] Timeout record: 03h, 07h, offset 01h, auto
// [R8] Catastrophic line: act on held low only
// [R9] Log catastrophic event, then query each CPU; the code queries each present CPU first and logs in C_DECIDE
// [R10] Mismatch: extra event, lamp, beep, hang
// [R11] No mismatch: reset unless disabled
// [R12] Catastrophic rearm on power-on, never resets
// [R13] Record source CPUs; no answer means unknown
// [R14] Type byte: 0 unknown, 1, 3 mismatch
// [R15] CPU bitmap byte: bit n is CPU n
// [R16] Catastrophic record: 03h, 07h, 01h, manual
// [R17] Mismatch record: 03h, 07h, 01h, power rearm
// [R18] Presence offset 7, sticky until rearm
// [R19] Timer restarts whenever the line deasserts
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module processor_fault_monitor
  import fault_mon_pkg::*;
#(
  parameter logic [NCPU-1:0] REQ_MASK = 4'h1,
  parameter logic [TW-1:0]   P_ERRTO  = TW'(ERRTO_CYC),
  parameter logic [TW-1:0]   P_BEEP   = TW'(BEEP_CYC),
  parameter logic [TW-1:0]   P_HOLD   = TW'(HOLD_CYC)
)(
  input  wire logic            CLK,
  input  wire logic            SRST,
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [31:0]     PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  input  wire logic [NCPU-1:0] CPU_PRESENT,
  input  wire logic [NCPU-1:0] FATAL_IO_ERROR_LINE,
  input  wire logic            CATASTROPHIC_ERROR_LINE_N,
  input  wire logic            MAIN_POWER_ON,
  input  wire logic            SYSTEM_RESET,
  output logic                 QUERY_REQ,
  output logic      [1:0]      QUERY_CPU,
  input  wire logic            QUERY_ACK,
  input  wire logic            QUERY_SOURCE,
  input  wire logic            QUERY_MISMATCH,
  output logic                 EVENT_VALID,
  input  wire logic            EVENT_READY,
  output event_s               EVENT_REC,
  output logic                 RESET_REQ,
  output logic                 FAULT_LED,
  output logic                 BEEP,
  output logic                 IRQ
);
  // ****************************************************
  // State
  // ****************************************************
  state_s q;           // Registered state
  state_s n;           // Next state
  logic   pwr_rise;    // Main power came on
  logic   rst_rise;    // System reset began
  logic   pres_smp;    // Presence is being sampled
  logic   cat_rearm;   // Catastrophic sensors rearmed
  logic   wr_hit;      // Completing APB write
  logic   pop_now;     // Current population fault

  assign pwr_rise = q.pwr_s2 & ~q.pwr_s3;
  assign rst_rise = q.rst_s2 & ~q.rst_s3;
  assign wr_hit   = PSEL & PENABLE & PWRITE & q.pready;
  assign pop_now  = |(REQ_MASK & ~q.pres_s2);

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb
  begin
    int         sel;
    logic       rearm_p;
    logic [NIRQ-1:0] iset;
    logic [31:0] rd;
    sel = NPEND;
    rearm_p = 1'b0;
    iset = '0;
    rd = '0;
    n = q;
    // Two-stage synchronisers for the presence, I/O error, catastrophic, power and reset pins
    n.pres_s1 = CPU_PRESENT;
    n.pres_s2 = q.pres_s1;
    n.io_s1   = FATAL_IO_ERROR_LINE;
    n.io_s2   = q.io_s1;
    n.cat_s1  = CATASTROPHIC_ERROR_LINE_N;
    n.cat_s2  = q.cat_s1;
    n.pwr_s1  = MAIN_POWER_ON;
    n.pwr_s2  = q.pwr_s1;
    n.pwr_s3  = q.pwr_s2;
    n.rst_s1  = SYSTEM_RESET;
    n.rst_s2  = q.rst_s1;
    n.rst_s3  = q.rst_s2;
    n.reset_req = 1'b0;
    // Startup waits for the synchronisers to fill
    if (q.init_cnt != 2'h0)
      n.init_cnt = q.init_cnt - 2'h1;

    // Event output: hand over, then load lowest pending slot
    if (q.evt_valid && EVENT_READY)
      n.evt_valid = 1'b0;
    if (!n.evt_valid)
    begin
      for (int k = NPEND - 1; k >= 0; k--)
        if (q.pend[k])
          sel = k;
    end
    if (sel < NPEND)
    begin
      n.pend[sel] = 1'b0;
      n.evt_valid = 1'b1;
      n.evt.deassert = q.pdir[sel];
      n.evt.rd_type = RD_TYPE;             // [R7] [R16] [R17]
      n.evt.sn_type = SN_TYPE;             // [R7] [R16] [R17]
      n.evt.offset = OFS_ASSERT;
      n.evt.ed2 = ED2_UNKNOWN;
      n.evt.ed3 = 8'h00;
      n.evt.cpu = 2'h0;
      if (sel < P_POP)
      begin
        n.evt.kind = K_PRES;
        n.evt.cpu = 2'(sel);
        n.evt.offset = OFS_PRESENT;        // [R18]
      end
      else if (sel == P_POP)
        n.evt.kind = K_POP;
      else if (sel < P_CAT)
      begin
        n.evt.kind = K_IOTO;
        n.evt.cpu = 2'(sel - P_IO);
      end
      else
      begin
        // Source and type only mean something on assertion
        n.evt.kind = (sel == P_CAT) ? K_CAT : K_SEGMENT_POWER_ID;
        if (!q.pdir[sel])
        begin
          if (!q.answered)
            n.evt.ed2 = ED2_UNKNOWN;       // [R13] [R14]
          else if (q.mismatch)
            n.evt.ed2 = ED2_MISMATCH;      // [R14]
          else
            n.evt.ed2 = ED2_CATASTROPHIC_ERROR_LINE;        // [R14]
          n.evt.ed3 = 8'({4'h0, q.src_map}); // [R15]
        end
      end
    end

    // Presence: startup, power-on, system reset or rearm
    rearm_p = wr_hit && PADDR[7:0] == A_REARM && PWDATA[0];
    if (pres_smp)                                    // [R1] [R2]
    begin
      for (int i = 0; i < NCPU; i++)
      begin
        // A rearm forgets the old state so every present CPU reports again
        if (q.pres_s2[i] != (rearm_p ? 1'b0 : q.present[i])) // [R3]
        begin
          n.pend[P_PRES+i] = 1'b1;
          n.pdir[P_PRES+i] = ~q.pres_s2[i];
          iset[0] = 1'b1;
        end
        n.present[i] = q.pres_s2[i];                 // [R18]
      end
    end

    // Population fault at startup and at each power-on
    if (q.init_cnt == 2'h1 || pwr_rise)              // [R4]
    begin
      n.pop_fault = pop_now;
      if (pop_now != q.pop_fault)
      begin
        n.pend[P_POP] = 1'b1;
        n.pdir[P_POP] = ~pop_now;
        iset[1] = 1'b1;
      end
      if (pwr_rise && pop_now)
        n.beep_cnt = P_BEEP;                         // [R4]
    end

    // Per-CPU fatal I/O error timers
    for (int i = 0; i < NCPU; i++)
    begin
      if (!q.io_s2[i])
      begin
        n.io_cnt[i] = '0;                            // [R19]
        if (q.io_to[i])
        begin
          // Auto rearm: deassertion is logged as well
          n.io_to[i] = 1'b0;                         // [R7]
          n.pend[P_IO+i] = 1'b1;
          n.pdir[P_IO+i] = 1'b1;
          iset[2] = 1'b1;
        end
      end
      else if (q.io_cnt[i] < P_ERRTO)
        n.io_cnt[i] = q.io_cnt[i] + TW'(1);
      else if (!q.io_to[i])
      begin
        // Held longer than the limit
        n.io_to[i] = 1'b1;                           // [R5]
        n.pend[P_IO+i] = 1'b1;                       // [R6]
        n.pdir[P_IO+i] = 1'b0;
        iset[2] = 1'b1;
        n.reset_req = ~q.ctrl[0];                    // [R6]
      end
    end

    // Low-time filter: short pulses never reach P_HOLD
    if (q.cat_s2)
      n.hold_cnt = '0;                               // [R8]
    else if (q.hold_cnt < P_HOLD)
      n.hold_cnt = q.hold_cnt + TW'(1);

    // Catastrophic error sequencer
    case (q.cst)
      C_IDLE:
      begin
        // Only a held-low line with an armed sensor starts it
        if (q.hold_cnt == P_HOLD && q.cat_armed)     // [R8]
        begin
          n.cat_armed = 1'b0;
          n.cat_asserted = 1'b1;
          n.qcpu = 2'h0;
          n.src_map = '0;
          n.mismatch = 1'b0;
          n.answered = 1'b0;
          n.cst = C_QUERY;                           // [R9]
        end
      end
      C_QUERY:
      begin
        // Empty sockets are skipped
        if (q.present[q.qcpu])
        begin
          n.qry_req = 1'b1;
          n.qry_cnt = 16'h0;
          n.cst = C_WAIT;
        end
        else if (q.qcpu == 2'(NCPU - 1))
          n.cst = C_DECIDE;
        else
          n.qcpu = q.qcpu + 2'h1;
      end
      C_WAIT:
      begin
        if (QUERY_ACK || q.qry_cnt == QRY_CYC)       // [R13]
        begin
          n.qry_req = 1'b0;
          if (QUERY_ACK)
          begin
            n.answered = 1'b1;
            n.src_map[q.qcpu] = QUERY_SOURCE;        // [R13]
            n.mismatch = q.mismatch | QUERY_MISMATCH;
          end
          if (q.qcpu == 2'(NCPU - 1))
            n.cst = C_DECIDE;
          else
          begin
            n.qcpu = q.qcpu + 2'h1;
            n.cst = C_QUERY;
          end
        end
        else
          n.qry_cnt = q.qry_cnt + 16'h1;
      end
      C_DECIDE:
      begin
        // Catastrophic slot outranks mismatch, so it logs first
        n.pend[P_CAT] = 1'b1;                        // [R9]
        n.pdir[P_CAT] = 1'b0;
        iset[3] = 1'b1;
        if (q.mismatch)
        begin
          n.segment_power_id_asserted = 1'b1;
          n.pend[P_SEGMENT_POWER_ID] = 1'b1;                     // [R10]
          n.pdir[P_SEGMENT_POWER_ID] = 1'b0;
          iset[4] = 1'b1;
          n.fault_led = 1'b1;                        // [R10]
          n.beep_cnt = P_BEEP;                       // [R10]
          n.cst = C_HUNG;
        end
        else
        begin
          n.reset_req = ~q.ctrl[1];                  // [R11]
          n.cst = C_IDLE;
        end
      end
      C_HUNG:
        n.cst = C_HUNG;                              // [R10]
      default:
        n.cst = C_IDLE;
    endcase

    // Rearm only on power-on or by software, never on reset
    if (cat_rearm)                                   // [R12] [R17]
    begin
      n.cat_armed = 1'b1;
      n.fault_led = 1'b0;
      n.cst = C_IDLE;
      if (q.cat_asserted)
      begin
        n.cat_asserted = 1'b0;
        n.pend[P_CAT] = 1'b1;                        // [R16]
        n.pdir[P_CAT] = 1'b1;
        iset[3] = 1'b1;
      end
      if (q.segment_power_id_asserted)
      begin
        n.segment_power_id_asserted = 1'b0;
        n.pend[P_SEGMENT_POWER_ID] = 1'b1;                       // [R17]
        n.pdir[P_SEGMENT_POWER_ID] = 1'b1;
        iset[4] = 1'b1;
      end
    end

    // Beeper runs for its own duration
    if (q.beep_cnt != '0 && n.beep_cnt == q.beep_cnt)
      n.beep_cnt = q.beep_cnt - TW'(1);
    n.beep = n.beep_cnt != '0;

    // APB: one wait state, writes take effect on the ready edge
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (PSEL && PENABLE && !q.pready)
    begin
      n.pready = 1'b1;
      case (PADDR[7:0])
        A_CTRL:  rd = {30'h0, q.ctrl};
        A_STAT:  rd = {17'h0, q.cst == C_HUNG, q.segment_power_id_asserted,
                       q.cat_asserted, q.io_to, 3'h0, q.pop_fault,
                       q.present};
        A_ISTAT: rd = {27'h0, q.istat};
        A_IEN:   rd = {27'h0, q.ien};
        A_LAST:  rd = {10'h0, q.evt.kind, q.evt.cpu, q.evt.deassert,
                       q.evt.ed2, q.evt.ed3};
        A_REARM, A_ICLR: rd = 32'h0;
        default: n.pslverr = 1'b1;
      endcase
      if (PADDR[31:8] != 24'h0)
        n.pslverr = 1'b1;
      n.prdata = n.pslverr ? 32'h0 : rd;
    end
    if (wr_hit && PADDR[31:8] == 24'h0)
    begin
      if (PADDR[7:0] == A_CTRL)
        n.ctrl = PWDATA[1:0];
      if (PADDR[7:0] == A_IEN)
        n.ien = PWDATA[NIRQ-1:0];
      if (PADDR[7:0] == A_ICLR)
        n.istat = q.istat & ~PWDATA[NIRQ-1:0];
    end
    // New events win over a clear in the same cycle
    n.istat = n.istat | iset;
    n.irq = |(n.istat & n.ien);
  end

  // Sample and rearm strobes shared with the checks
  assign pres_smp = q.init_cnt == 2'h1 || pwr_rise || rst_rise ||
                    (wr_hit && PADDR[7:0] == A_REARM && PWDATA[0]);
  assign cat_rearm = (pwr_rise ||
                      (wr_hit && PADDR[7:0] == A_REARM && PWDATA[1])) &&
                     (q.cst == C_IDLE || q.cst == C_HUNG);

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      // Standby power-on restart: sensors cleared and armed
      q <= '0;                                       // [R1] [R12]
      q.cat_s1 <= 1'b1;
      q.cat_s2 <= 1'b1;
      q.init_cnt <= INIT_RST;
      q.cat_armed <= 1'b1;
      q.ctrl <= CTRL_RST;
    end
    else
      q <= n;
  end

  // Outputs straight from the state register
  assign PRDATA      = q.prdata;
  assign PREADY      = q.pready;
  assign PSLVERR     = q.pslverr;
  assign QUERY_REQ   = q.qry_req;
  assign QUERY_CPU   = q.qcpu;
  assign EVENT_VALID = q.evt_valid;
  assign EVENT_REC   = q.evt;
  assign RESET_REQ   = q.reset_req;
  assign FAULT_LED   = q.fault_led;
  assign BEEP        = q.beep;
  assign IRQ         = q.irq;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  tmo_fire_a: assert property ( // [R5]
    $rose(q.io_to[0]) |-> $past(q.io_s2[0]) && q.io_cnt[0] == P_ERRTO)
    else $error("timeout raised before the limit");
  tmo_restart_a: assert property ( // [R19]
    !q.io_s2[0] |=> q.io_cnt[0] == '0 && !q.io_to[0])
    else $error("timer kept counting after deassert");
  tmo_reset_a: assert property ( // [R6]
    $rose(q.io_to[0]) && !$past(q.ctrl[0]) |-> RESET_REQ)
    else $error("timeout did not request reset");
  rec_codes_a: assert property ( // [R7]
    EVENT_VALID |-> EVENT_REC.rd_type == 8'h03 &&
      EVENT_REC.sn_type == 8'h07)
    else $error("event record codes wrong");
  pulse_ignore_a: assert property ( // [R8]
    q.cst == C_IDLE && q.hold_cnt != P_HOLD |=> q.cst == C_IDLE)
    else $error("low pulse started the sequence");
  cat_log_a: assert property ( // [R9]
    q.cst == C_DECIDE |=> q.pend[P_CAT] || EVENT_VALID)
    else $error("catastrophic event not logged");
  hang_hold_a: assert property ( // [R10]
    q.cst == C_HUNG |-> FAULT_LED && !RESET_REQ ##1 q.cst == C_HUNG ||
      $past(cat_rearm))
    else $error("hang released without rearm");
  no_reset_rearm_a: assert property ( // [R12]
    rst_rise && !q.cat_armed && !cat_rearm |=> !q.cat_armed)
    else $error("system reset rearmed sensor");
  pres_sticky_a: assert property ( // [R18]
    !pres_smp |=> $stable(q.present))
    else $error("presence changed outside sampling");
  pop_beep_a: assert property ( // [R4]
    pwr_rise && pop_now |=> BEEP)
    else $error("no beep on failed power-on");

  tmo_seen_c: cover property ($rose(q.io_to[0]));
  hang_seen_c: cover property (q.cst == C_DECIDE && q.mismatch);
  cat_reset_c: cover property (q.cst == C_DECIDE ##1 RESET_REQ);
  pres_evt_c: cover property (EVENT_VALID && EVENT_REC.kind == K_PRES);
endmodule
`default_nettype wire

//--- tb/cpu_query_model.sv
// Sideband query partner standing for the processor sockets
`timescale 1ns/1ns
`default_nettype none
module cpu_query_model
  import fault_mon_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            responsive,
  input  wire logic [NCPU-1:0] src_map,
  input  wire logic [NCPU-1:0] bad_map,
  input  wire logic            req,
  input  wire logic [1:0]      cpu,
  output logic                 ack,
  output logic                 src,
  output logic                 bad
);
  logic [1:0] wait_q = 2'h0; // Cycles spent on the current request

  initial
  begin
    ack = 1'b0;
    src = 1'b0;
    bad = 1'b0;
  end

  // Answer three cycles into a request; a dead port never answers
  always @(posedge clk)
  begin
    ack <= 1'b0;
    // Off-cycle answer lines toggle so no stale value looks valid
    src <= ~src;
    bad <= ~bad;
    if (req && !ack && responsive)
    begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == 2'h2)
      begin
        ack <= 1'b1;
        src <= src_map[cpu];
        bad <= bad_map[cpu];
        wait_q <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/processor_fault_monitor_test.sv
// Self-checking bench of the processor fault monitor
`timescale 1ns/1ns
`default_nettype none
module processor_fault_monitor_test
  import fault_mon_pkg::*;
;
  logic            clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic            pwrite = 1'b0, pready, pslverr, er;
  logic [31:0]     paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [NCPU-1:0] present = 4'h3, ioerr = 4'h0, src_m = 4'h0;
  logic [NCPU-1:0] bad_m = 4'h0;
  logic            cat_n = 1'b1, pwr_on = 1'b0, sys_rst = 1'b0;
  logic            resp = 1'b1, qreq, qack, qsrc, qbad, beep_q = 1'b0;
  logic            ev_rdy = 1'b1; // Log side accepts records
  logic [1:0]      qcpu;
  logic            ev_valid, rst_req, led, beep, irq;
  event_s          ev_rec;
  event_s          evq[$];   // Records handed over, oldest first
  int              num_errors = 0, checks = 0, rst_cnt = 0, beep_cnt = 0;
  int              n0, b0;
  typedef struct packed {
    logic        resp;
    logic [3:0]  src, bad;
    logic [15:0] ed;
    logic        rst;
  } cat_row_s;
  // Catastrophic cases: answering mode, answers, type/bitmap, reset
  cat_row_s rows [3] = '{'{1'b1, 4'h2, 4'h2, 16'h0302, 1'b0},
                         '{1'b1, 4'h1, 4'h0, 16'h0101, 1'b1},
                         '{1'b0, 4'h3, 4'h0, 16'h0000, 1'b1}};

  always #10 clk = ~clk;

  // Short counts keep the 90 s timeout and beep inside the run
  processor_fault_monitor #(.P_ERRTO(33'h32), .P_BEEP(33'hA),
    .P_HOLD(33'h8)) DUT (.CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CPU_PRESENT(present), .FATAL_IO_ERROR_LINE(ioerr),
    .CATASTROPHIC_ERROR_LINE_N(cat_n), .MAIN_POWER_ON(pwr_on),
    .SYSTEM_RESET(sys_rst), .QUERY_REQ(qreq), .QUERY_CPU(qcpu),
    .QUERY_ACK(qack), .QUERY_SOURCE(qsrc), .QUERY_MISMATCH(qbad),
    .EVENT_VALID(ev_valid), .EVENT_READY(ev_rdy), .EVENT_REC(ev_rec),
    .RESET_REQ(rst_req), .FAULT_LED(led), .BEEP(beep), .IRQ(irq));

  cpu_query_model partner (.clk(clk), .responsive(resp), .src_map(src_m),
    .bad_map(bad_m), .req(qreq), .cpu(qcpu), .ack(qack), .src(qsrc),
    .bad(qbad));

  // Collect records and count one-cycle actions at each edge
  always @(posedge clk)
  begin
    if (ev_valid === 1'b1 && ev_rdy)
      evq.push_back(ev_rec);
    if (rst_req === 1'b1)
      rst_cnt++;
    if (beep === 1'b1 && beep_q !== 1'b1)
      beep_cnt++;
    beep_q <= beep;
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      num_errors++;
  endtask

  // Next record; m picks fields: 1 cpu, 2 offset, 4 codes, 8 data
  task automatic expect_ev(input kind_e k, input logic [1:0] c,
    input logic dz, input logic [7:0] o, input logic [15:0] ed,
    input logic [3:0] m);
    event_s e;
    int     n = 0;
    while (evq.size() == 0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
      num_errors++;
    e = (evq.size() > 0) ? evq.pop_front() : '0;
    chk(32'(e.kind), 32'(k));
    if (m[0]) chk(32'(e.cpu), 32'(c));
    if (m[1]) chk(32'(e.offset), 32'(o));
    if (m[2]) chk(32'({e.deassert, e.rd_type, e.sn_type}),
                  32'({dz, RD_TYPE, SN_TYPE}));
    if (m[3]) chk(32'({e.ed2, e.ed3}), 32'(ed));
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    tick(3);
    chk(32'({rst_req, irq, ev_valid, led}), 32'h0);
    srst <= 1'b0;
    // Log side stalls: the record must stand, not be lost
    ev_rdy <= 1'b0;
    tick(10);
    chk(32'(ev_valid), 32'h1);
    ev_rdy <= 1'b1;
    expect_ev(K_PRES, 2'h0, 1'b0, OFS_PRESENT, 16'h0, 4'h3);
    expect_ev(K_PRES, 2'h1, 1'b0, OFS_PRESENT, 16'h0, 4'h3);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h1F, 32'h3);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RST));
    apb(1'b0, 8'h1C, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    chk(32'(irq), 32'h0);
    apb(1'b1, A_REARM, 32'h1);
    expect_ev(K_PRES, 2'h0, 1'b0, OFS_PRESENT, 16'h0, 4'h3);
    expect_ev(K_PRES, 2'h1, 1'b0, OFS_PRESENT, 16'h0, 4'h3);
    $display("startup test done");
    // Power-on with the required socket empty
    present <= 4'h2;
    pwr_on <= 1'b1;
    tick(4);
    pwr_on <= 1'b0;
    expect_ev(K_PRES, 2'h0, 1'b1, OFS_PRESENT, 16'h0, 4'h3);
    expect_ev(K_POP, 2'h0, 1'b0, 8'h0, 16'h0, 4'h0);
    tick(20);
    chk(32'(beep_cnt), 32'h1);
    present <= 4'h3;
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    expect_ev(K_PRES, 2'h0, 1'b0, OFS_PRESENT, 16'h0, 4'h3);
    $display("power-on test done");
    // Broken stretch never times out; reset unless disabled by CTRL bit 0
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, A_CTRL, 32'(i));
      evq.delete();
      n0 = rst_cnt;
      ioerr[i] <= 1'b1;
      tick(30);
      ioerr[i] <= 1'b0;
      tick(4);
      ioerr[i] <= 1'b1;
      tick(40);
      chk(32'(evq.size()), 32'h0);
      expect_ev(K_IOTO, 2'(i), 1'b0, OFS_ASSERT, 16'h0, 4'h7);
      tick(5);
      chk(32'(rst_cnt - n0), 32'(1 - i));
      ioerr[i] <= 1'b0;
      expect_ev(K_IOTO, 2'(i), 1'b1, OFS_ASSERT, 16'h0, 4'h7);
    end
    apb(1'b1, A_CTRL, 32'h0);
    $display("timeout test done");
    // A short low pulse must be ignored
    cat_n <= 1'b0;
    tick(4);
    cat_n <= 1'b1;
    tick(30);
    chk(32'(evq.size()), 32'h0);
    apb(1'b1, A_IEN, 32'h8);
    foreach (rows[r])
    begin
      resp <= rows[r].resp;
      src_m <= rows[r].src;
      bad_m <= rows[r].bad;
      n0 = rst_cnt;
      b0 = beep_cnt;
      cat_n <= 1'b0;
      expect_ev(K_CAT, 2'h0, 1'b0, OFS_ASSERT, rows[r].ed,
                4'hE);
      tick(20);
      chk(32'(rst_cnt - n0), 32'(rows[r].rst));
      if (r == 0)
      begin
        expect_ev(K_SEGMENT_POWER_ID, 2'h0, 1'b0, OFS_ASSERT, 16'h0,
                  4'h6);
        chk(32'({led, irq}), 32'h3);
        chk(32'(beep_cnt - b0), 32'h1);
        apb(1'b1, A_ICLR, 32'h8);
        tick(2);
        chk(32'(irq), 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[14]), 32'h1);
        sys_rst <= 1'b1;
        tick(4);
        sys_rst <= 1'b0;
        tick(20);
        chk(32'(evq.size()), 32'h0);
      end
      cat_n <= 1'b1;
      tick(5);
      apb(1'b1, A_REARM, 32'h2);
      if (r == 0)
        expect_ev(K_CAT, 2'h0, 1'b1, OFS_ASSERT, 16'h0, 4'h6);
      tick(30);
      evq.delete();
    end
    $display("catastrophic test done");
    conclude();
  end

  // Whole run is under two thousand cycles; allow ample margin
  initial
  begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
